// ===== jtag_ctrl_model.sv
/*
 * Behavioural boundary-scan test controller that drives the test port pins.
 * Assumes the caller starts a scan from Run-Test-Idle; TCK rests low between frames.
 */
`timescale 1ns/100ps

module jtag_ctrl_model (
   output logic       tck,     // Test clock, 80 ns period inside frames
   output logic       tms,     // Mode select
   output logic       tdi,     // Serial data to the device
   output logic       trst_n,  // Test reset, active low
   input  wire logic  tdo,     // Serial data from the device
   input  wire logic  tdo_oe   // Device drive enable on TDO
);
   logic oe_all;  // AND of tdo_oe over the shifting ticks of the latest shift

   initial begin
      tck    = 1'b0;
      tms    = 1'b1;
      tdi    = 1'b0;
      trst_n = 1'b1;
      oe_all = 1'b1;
   end

   // ------------------------------------------------------------------------
   // One TCK period; TDO is taken just before the rising edge
   // ------------------------------------------------------------------------
   task automatic tick(input logic m, input logic d, input logic sh, output logic q);
      tms = m;
      tdi = sh ? d : ~tdi;  // Data line toggles when it carries nothing
      #40;
      q = tdo;
      if (sh) oe_all = oe_all & tdo_oe;
      tck = 1'b1;
      #40;
      tck = 1'b0;
   endtask : tick

   // Non-shifting steps, TMS taken from seq LSB first
   task automatic walk(input logic [7:0] seq, input int n);
      logic q;
      for (int i = 0; i < n; i++) tick(seq[i], 1'b0, 1'b0, q);
   endtask : walk

   // Shift n bits LSB first, last bit with TMS high to leave the shift state
   task automatic shift(input logic [31:0] din, input int n, output logic [31:0] dout);
      dout   = 32'h0000_0000;
      oe_all = 1'b1;
      for (int i = 0; i < n; i++) tick(i == n - 1, din[i], 1'b1, dout[i]);
   endtask : shift

   // Five TMS-high ticks reach Test-Logic-Reset, one low tick reaches idle
   task automatic reset_tlr();
      walk(8'h1F, 6);
   endtask : reset_tlr

   // Instruction scan: bits shift in during Shift-IR, Update-IR latches the instruction
   task automatic scan_ir(input logic [3:0] ins, output logic [3:0] cap);
      logic [31:0] d;
      walk(8'h03, 4);
      shift({28'h000_0000, ins}, 4, d);
      cap = d[3:0];
      walk(8'h01, 2);
   endtask : scan_ir

   // Data scan through whatever register the instruction selects
   task automatic scan_dr(input logic [31:0] din, input int n, output logic [31:0] dout);
      walk(8'h01, 3);
      shift(din, n, dout);
      walk(8'h01, 2);
   endtask : scan_dr
endmodule : jtag_ctrl_model

// ===== jtag_defines.svh
/*
 * Constants of the boundary-scan instruction decoder: instruction codes,
 * capture patterns, register lengths and identification fields.
 * Assumes it is included by bare name from every design file that needs it.
 */
// How it works
// - Instruction bits shift in from TDI only while the TAP is in Shift-IR.
// - Instruction register is four bits wide, sixteen possible codes.
// - Code 0x02 puts the 32-bit identification register between TDI and TDO.
// - Identification instruction keeps the device in normal functional mode.
// - Power-up, TRST or Test-Logic-Reset make identification the current instruction.
// - Code 0x01 selects the boundary-scan register and keeps normal operation.
// - Sample/preload capture snapshots functional signals into the boundary-scan register.
// - Code 0x03 forces every device output into high impedance.
// - High-impedance instruction routes the bypass bit; shifting keeps outputs released.
// - Code 0x0F selects the one-bit bypass register with normal operation.
// - No external-test instruction; pins are never driven from scan cells.
// - Unselected data registers stay out of the path and undisturbed.
// - Capture-IR loads a fixed pattern ending in binary 01.
// - Update-IR latches the shifted instruction on the falling TCK edge.
// - Selected bypass stage loads zero on the rising edge in Capture-DR.
// - Identification word holds version, part, 11-bit maker field and LSB one.
`ifndef JTAG_DEFINES_SVH
`define JTAG_DEFINES_SVH

// ----------------------------------------------------------------------------
// Instruction register
// ----------------------------------------------------------------------------
`define IR_LEN          4
`define IR_CAPTURE      4'h1
`define INS_SAMPLE      4'h1
`define INS_IDCODE      4'h2
`define INS_HIGHZ       4'h3
`define INS_BYPASS      4'hF
`define INS_RESET       4'h2

// ----------------------------------------------------------------------------
// Data registers
// ----------------------------------------------------------------------------
`define ID_LEN          32
`define ID_VER_LEN      4
`define ID_PART_LEN     16
`define ID_MFR_LEN      11
`define BSR_LEN         16

// ----------------------------------------------------------------------------
// Pin synchroniser
// ----------------------------------------------------------------------------
`define SYNC_W          4
`define SYNC_RST        4'h0
`define PIN_TCK         0
`define PIN_TMS         1
`define PIN_TDI         2
`define PIN_TRSTN       3

`endif

// ===== jtag_instruction_decode.sv
/*
 * Boundary-scan instruction register, decoder and test data registers.
 * Assumes TCK, TMS, TDI and TRST come from an external test controller
 * asynchronous to clk, and TCK is much slower than clk.
 */
`timescale 1ns/100ps
`include "jtag_defines.svh"

module jtag_instruction_decode #(
   parameter logic [`ID_VER_LEN-1:0]  ID_VERSION = 4'h0,     // Version field
   parameter logic [`ID_PART_LEN-1:0] ID_PART    = 16'h1234, // Arbitrary value
   parameter logic [`ID_MFR_LEN-1:0]  ID_MFR     = 11'h05A   // Arbitrary value
) (
   input  wire logic                 clk,          // Core clock, 250 MHz
   input  wire logic                 rst_n,        // Power-up reset, active low
   input  wire logic                 tck,          // Test clock pin
   input  wire logic                 tms,          // Test mode select pin
   input  wire logic                 tdi,          // Test data in pin
   input  wire logic                 trst_n,       // Test reset pin, active low
   input  wire logic [`BSR_LEN-1:0]  func_sig,     // Functional pin levels to sample
   output logic                      tdo,          // Test data out
   output logic                      tdo_oe,       // TDO drive enable
   output logic                      outputs_hiz,  // Force all device outputs off
   output logic [`IR_LEN-1:0]        instr_cur     // Current instruction
);

   // -------------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------------
   localparam logic [`ID_LEN-1:0] ID_WORD = {ID_VERSION, ID_PART, ID_MFR, 1'b1};

   logic [`SYNC_W-1:0]     pin_lvl;
   logic                   tck_prev_ff;
   jtag_pkg::tap_state_t   tap_state;
   logic [`IR_LEN-1:0]     ir_shift_ff;
   logic [`IR_LEN-1:0]     instr_ff;
   logic [`ID_LEN-1:0]     id_shift_ff;
   logic [`BSR_LEN-1:0]    bsr_ff;
   logic                   bypass_ff;
   logic                   tdo_ff;
   logic                   tdo_oe_ff;
   logic                   hiz_ff;

   // -------------------------------------------------------------------------
   // Pin synchronisation and TCK edges
   // -------------------------------------------------------------------------
   pin_sync u_sync (
      .clk    (clk),
      .rst_n  (rst_n),
      .pin_in ({trst_n, tdi, tms, tck}),
      .lvl_ff (pin_lvl)
   );

   // Previous filtered TCK level for edge detection
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tck_prev_ff <= 1'b0;
      end else begin
         tck_prev_ff <= pin_lvl[`PIN_TCK];
      end
   end

   // Edge pulses and filtered pins
   wire tck_rise  = pin_lvl[`PIN_TCK] & ~tck_prev_ff;
   wire tck_fall  = ~pin_lvl[`PIN_TCK] & tck_prev_ff;
   wire tms_lvl   = pin_lvl[`PIN_TMS];
   wire tdi_lvl   = pin_lvl[`PIN_TDI];
   wire trstn_lvl = pin_lvl[`PIN_TRSTN];

   // -------------------------------------------------------------------------
   // TAP controller
   // -------------------------------------------------------------------------
   tap_fsm u_tap (
      .clk      (clk),
      .rst_n    (rst_n),
      .trst_n   (trstn_lvl),
      .tck_rise (tck_rise),
      .tms      (tms_lvl),
      .state_ff (tap_state)
   );

   // State decodes
   wire in_tlr   = (tap_state == jtag_pkg::TLR);
   wire cap_ir   = tck_rise && (tap_state == jtag_pkg::CAPTURE_IR);
   wire shf_ir   = tck_rise && (tap_state == jtag_pkg::SHIFT_IR);
   wire upd_ir   = tck_fall && (tap_state == jtag_pkg::UPDATE_IR);
   wire cap_dr   = tck_rise && (tap_state == jtag_pkg::CAPTURE_DR);
   wire shf_dr   = tck_rise && (tap_state == jtag_pkg::SHIFT_DR);
   wire in_shift = (tap_state == jtag_pkg::SHIFT_IR) || (tap_state == jtag_pkg::SHIFT_DR);

   // -------------------------------------------------------------------------
   // Instruction decode
   // -------------------------------------------------------------------------
   // Only identification and sample pick a long register; all else is bypass
   wire sel_id     = (instr_ff == `INS_IDCODE);
   wire sel_bsr    = (instr_ff == `INS_SAMPLE);
   wire sel_bypass = !sel_id && !sel_bsr;
   wire ins_hiz    = (instr_ff == `INS_HIGHZ);

   // -------------------------------------------------------------------------
   // Instruction shift stage and latch
   // -------------------------------------------------------------------------
   // Shift stage: fixed pattern at capture, TDI in at the top while shifting
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ir_shift_ff <= `IR_CAPTURE;
      end else if (cap_ir) begin
         ir_shift_ff <= `IR_CAPTURE;
      end else if (shf_ir) begin
         ir_shift_ff <= {tdi_lvl, ir_shift_ff[`IR_LEN-1:1]};
      end
   end

   // Latch: reset states return to identification, update on falling TCK
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         instr_ff <= `INS_RESET;
      end else if (in_tlr) begin
         instr_ff <= `INS_RESET;
      end else if (upd_ir) begin
         instr_ff <= ir_shift_ff;
      end
   end

   // -------------------------------------------------------------------------
   // Test data registers
   // -------------------------------------------------------------------------
   // Identification register; read-only word, only moves when selected
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         id_shift_ff <= '0;
      end else if (cap_dr && sel_id) begin
         id_shift_ff <= ID_WORD;
      end else if (shf_dr && sel_id) begin
         id_shift_ff <= {tdi_lvl, id_shift_ff[`ID_LEN-1:1]};
      end
   end

   // Boundary-scan register; snapshot of functional signals, never drives pins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bsr_ff <= '0;
      end else if (cap_dr && sel_bsr) begin
         bsr_ff <= func_sig;
      end else if (shf_dr && sel_bsr) begin
         bsr_ff <= {tdi_lvl, bsr_ff[`BSR_LEN-1:1]};
      end
   end

   // Bypass stage; zero at capture, one bit of delay while shifting
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bypass_ff <= 1'b0;
      end else if (cap_dr && sel_bypass) begin
         bypass_ff <= 1'b0;
      end else if (shf_dr && sel_bypass) begin
         bypass_ff <= tdi_lvl;
      end
   end

   // -------------------------------------------------------------------------
   // TDO path, updated on falling TCK
   // -------------------------------------------------------------------------
   wire dr_bit  = sel_id  ? id_shift_ff[0] :
                  sel_bsr ? bsr_ff[0]      : bypass_ff;
   wire nxt_tdo = (tap_state == jtag_pkg::SHIFT_IR) ? ir_shift_ff[0] : dr_bit;

   // TDO driven only in the shift states
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tdo_ff    <= 1'b0;
         tdo_oe_ff <= 1'b0;
      end else if (tck_fall) begin
         tdo_ff    <= nxt_tdo;
         tdo_oe_ff <= in_shift;
      end
   end

   // -------------------------------------------------------------------------
   // Output release control
   // -------------------------------------------------------------------------
   // Only the high-impedance code releases outputs; shifting leaves it alone
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hiz_ff <= 1'b0;
      end else begin
         hiz_ff <= ins_hiz;
      end
   end

   // Output drive
   assign tdo         = tdo_ff;
   assign tdo_oe      = tdo_oe_ff;
   assign outputs_hiz = hiz_ff;
   assign instr_cur   = instr_ff;

   // -------------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_upd_fall;
      tck_fall && (tap_state == jtag_pkg::UPDATE_IR) && !in_tlr;
   endsequence

   sequence s_cap_id;
      tck_rise && (tap_state == jtag_pkg::CAPTURE_DR) && sel_id;
   endsequence

   a_ir_capture: assert property (cap_ir |=> ir_shift_ff == 4'h1)
      else $error("Capture-IR pattern wrong");

   a_ir_hold: assert property (
      !$past(shf_ir) && !$past(cap_ir) |-> $stable(ir_shift_ff))
      else $error("Instruction shift stage moved outside Shift-IR");

   a_ir_update: assert property (
      s_upd_fall |=> instr_ff == $past(ir_shift_ff))
      else $error("Update-IR did not latch the instruction");

   a_reset_idcode: assert property (
      in_tlr |=> instr_ff == 4'h2)
      else $error("Test-Logic-Reset did not select identification");

   a_id_capture: assert property (
      s_cap_id |=> (id_shift_ff == ID_WORD) && id_shift_ff[0])
      else $error("Identification capture wrong");

   a_bsr_capture: assert property (
      cap_dr && sel_bsr |=> bsr_ff == $past(func_sig))
      else $error("Boundary snapshot not captured");

   a_bypass_zero: assert property (
      cap_dr && sel_bypass |=> !bypass_ff)
      else $error("Bypass stage not cleared at capture");

   a_undef_bypass: assert property (
      (instr_ff != 4'h1) && (instr_ff != 4'h2) |-> sel_bypass)
      else $error("Undecoded instruction did not pick bypass");

   a_hiz_follow: assert property (
      (instr_ff == 4'h3) ##1 (instr_ff == 4'h3) |-> outputs_hiz)
      else $error("High-impedance instruction did not release outputs");

   a_hiz_normal: assert property (
      (instr_ff != 4'h3) ##1 (instr_ff != 4'h3) |-> !outputs_hiz)
      else $error("Outputs released under a normal-mode instruction");

   a_id_quiet: assert property (
      !sel_id && !$past(in_tlr) |=> $stable(id_shift_ff))
      else $error("Unselected identification register moved");

   a_tdo_path: assert property (
      tck_fall && (tap_state == jtag_pkg::SHIFT_DR) |=> tdo_oe && (tdo == $past(dr_bit)))
      else $error("TDO does not follow the selected register");

endmodule : jtag_instruction_decode

// ===== jtag_pkg.sv
/*
 * Types of the boundary-scan instruction decoder: the TAP controller states.
 * Assumes jtag_defines.svh sits in the same folder.
 */
package jtag_pkg;

   // -------------------------------------------------------------------------
   // TAP controller states
   // -------------------------------------------------------------------------
   typedef enum logic [3:0] {
      TLR        = 4'h0,
      RTI        = 4'h1,
      SEL_DR     = 4'h2,
      CAPTURE_DR = 4'h3,
      SHIFT_DR   = 4'h4,
      EXIT1_DR   = 4'h5,
      PAUSE_DR   = 4'h6,
      EXIT2_DR   = 4'h7,
      UPDATE_DR  = 4'h8,
      SEL_IR     = 4'h9,
      CAPTURE_IR = 4'hA,
      SHIFT_IR   = 4'hB,
      EXIT1_IR   = 4'hC,
      PAUSE_IR   = 4'hD,
      EXIT2_IR   = 4'hE,
      UPDATE_IR  = 4'hF
   } tap_state_t;

endpackage : jtag_pkg

// ===== pin_sync.sv
/*
 * Three-stage synchroniser for the test port pins.
 * Assumes pins are asynchronous to clk; an output follows once stages two
 * and three agree, so a one-sample glitch is never seen.
 */
`timescale 1ns/100ps
`include "jtag_defines.svh"

module pin_sync (
   input  wire logic                clk,      // Core clock
   input  wire logic                rst_n,    // Async reset, active low
   input  wire logic [`SYNC_W-1:0]  pin_in,   // Raw pins
   output logic      [`SYNC_W-1:0]  lvl_ff    // Filtered levels
);

   logic [`SYNC_W-1:0] s1_ff;
   logic [`SYNC_W-1:0] s2_ff;
   logic [`SYNC_W-1:0] s3_ff;

   // -------------------------------------------------------------------------
   // One synchroniser per pin
   // -------------------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < `SYNC_W; gi = gi + 1) begin : g_pin
         // Stage chain; stage one is read only by stage two
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               s1_ff[gi]  <= 1'b0;
               s2_ff[gi]  <= 1'b0;
               s3_ff[gi]  <= 1'b0;
               lvl_ff[gi] <= 1'b0;
            end else begin
               s1_ff[gi] <= pin_in[gi];
               s2_ff[gi] <= s1_ff[gi];
               s3_ff[gi] <= s2_ff[gi];
               if (s2_ff[gi] == s3_ff[gi]) begin
                  lvl_ff[gi] <= s3_ff[gi];
               end
            end
         end
      end
   endgenerate

endmodule : pin_sync

// ===== tap_fsm.sv
/*
 * TAP controller state machine, stepped once per rising TCK edge.
 * Assumes tck_rise is a one-cycle pulse and tms is already synchronised.
 */
`timescale 1ns/100ps
`include "jtag_defines.svh"

module tap_fsm (
   input  wire logic               clk,       // Core clock
   input  wire logic               rst_n,     // Async reset, active low
   input  wire logic               trst_n,    // Synchronised test reset, active low
   input  wire logic               tck_rise,  // Rising TCK pulse
   input  wire logic               tms,       // Synchronised mode select
   output jtag_pkg::tap_state_t    state_ff   // Current state
);

   jtag_pkg::tap_state_t nxt_state;

   // -------------------------------------------------------------------------
   // Next state from TMS
   // -------------------------------------------------------------------------
   always_comb begin
      case (state_ff)
         jtag_pkg::TLR:        nxt_state = tms ? jtag_pkg::TLR       : jtag_pkg::RTI;
         jtag_pkg::RTI:        nxt_state = tms ? jtag_pkg::SEL_DR    : jtag_pkg::RTI;
         jtag_pkg::SEL_DR:     nxt_state = tms ? jtag_pkg::SEL_IR    : jtag_pkg::CAPTURE_DR;
         jtag_pkg::CAPTURE_DR: nxt_state = tms ? jtag_pkg::EXIT1_DR  : jtag_pkg::SHIFT_DR;
         jtag_pkg::SHIFT_DR:   nxt_state = tms ? jtag_pkg::EXIT1_DR  : jtag_pkg::SHIFT_DR;
         jtag_pkg::EXIT1_DR:   nxt_state = tms ? jtag_pkg::UPDATE_DR : jtag_pkg::PAUSE_DR;
         jtag_pkg::PAUSE_DR:   nxt_state = tms ? jtag_pkg::EXIT2_DR  : jtag_pkg::PAUSE_DR;
         jtag_pkg::EXIT2_DR:   nxt_state = tms ? jtag_pkg::UPDATE_DR : jtag_pkg::SHIFT_DR;
         jtag_pkg::UPDATE_DR:  nxt_state = tms ? jtag_pkg::SEL_DR    : jtag_pkg::RTI;
         jtag_pkg::SEL_IR:     nxt_state = tms ? jtag_pkg::TLR       : jtag_pkg::CAPTURE_IR;
         jtag_pkg::CAPTURE_IR: nxt_state = tms ? jtag_pkg::EXIT1_IR  : jtag_pkg::SHIFT_IR;
         jtag_pkg::SHIFT_IR:   nxt_state = tms ? jtag_pkg::EXIT1_IR  : jtag_pkg::SHIFT_IR;
         jtag_pkg::EXIT1_IR:   nxt_state = tms ? jtag_pkg::UPDATE_IR : jtag_pkg::PAUSE_IR;
         jtag_pkg::PAUSE_IR:   nxt_state = tms ? jtag_pkg::EXIT2_IR  : jtag_pkg::PAUSE_IR;
         jtag_pkg::EXIT2_IR:   nxt_state = tms ? jtag_pkg::UPDATE_IR : jtag_pkg::SHIFT_IR;
         jtag_pkg::UPDATE_IR:  nxt_state = tms ? jtag_pkg::SEL_DR    : jtag_pkg::RTI;
         default:              nxt_state = jtag_pkg::TLR;
      endcase
   end

   // State register; test reset forces Test-Logic-Reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= jtag_pkg::TLR;
      end else if (!trst_n) begin
         state_ff <= jtag_pkg::TLR;
      end else if (tck_rise) begin
         state_ff <= nxt_state;
      end
   end

endmodule : tap_fsm

// ===== tb_jtag_instruction_decode.sv
/*
 * Self-checking testbench for the boundary-scan instruction decoder.
 * Assumes jtag_ctrl_model drives the test pins and the design files are compiled first.
 */
`timescale 1ns/100ps

module tb_jtag_instruction_decode;
   // Identification fields, arbitrary values
   localparam logic [31:0] ID_WORD = {4'h3, 16'hC0DE, 11'h2A5, 1'h1};
   localparam logic [31:0] DIN     = 32'h9E37_4B1D;

   typedef struct packed {logic [3:0] code; logic hiz; logic [1:0] sel;} row_t;
   // sel: 0 bypass, 1 boundary register, 2 identification
   row_t rows [8] = '{'{4'h2, 1'h0, 2'h2}, '{4'h1, 1'h0, 2'h1}, '{4'h3, 1'h1, 2'h0},
                      '{4'hF, 1'h0, 2'h0}, '{4'h0, 1'h0, 2'h0}, '{4'h4, 1'h0, 2'h0},
                      '{4'h8, 1'h0, 2'h0}, '{4'hE, 1'h0, 2'h0}};

   logic        clk      = 1'b0;
   logic        rst_n    = 1'b0;
   logic [15:0] func_sig = 16'h0000;
   logic [31:0] dout;
   logic [3:0]  cap;
   logic        tck, tms, tdi, trst_n, tdo, tdo_oe, outputs_hiz;
   logic [3:0]  instr_cur;
   int          num_errors   = 0;
   int          total_checks = 0;

   always #2 clk = ~clk;

   jtag_instruction_decode #(.ID_VERSION(4'h3), .ID_PART(16'hC0DE), .ID_MFR(11'h2A5))
      u_jtag_instruction_decode (.clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
         .trst_n(trst_n), .func_sig(func_sig), .tdo(tdo), .tdo_oe(tdo_oe),
         .outputs_hiz(outputs_hiz), .instr_cur(instr_cur));

   jtag_ctrl_model u_jtag_ctrl_model (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
      .tdo(tdo), .tdo_oe(tdo_oe));

   // ------------------------------------------------------------------------
   // Comparison, expected data and closing report
   // ------------------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   function automatic logic [31:0] exp_dr(input logic [1:0] sel, input logic [15:0] fs);
      case (sel)
         2'h2:    return ID_WORD;
         2'h1:    return {DIN[15:0], fs};
         default: return {DIN[30:0], 1'h0};
      endcase
   endfunction : exp_dr

   task automatic end_of_test();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : end_of_test

   // Load an instruction and check the decoded outputs
   task automatic load_ir(input logic [3:0] code, input logic hiz);
      u_jtag_ctrl_model.scan_ir(code, cap);
      #100;
      check("ir capture", 32'(cap), 32'h1);
      check("instr", 32'(instr_cur), 32'(code));
      check("hiz", 32'(outputs_hiz), 32'(hiz));
   endtask : load_ir

   // Watchdog
   initial begin
      #400000;
      num_errors++;
      $display("ERROR watchdog expired");
      end_of_test();
   end

   // ------------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------------
   initial begin
      repeat (5) @(posedge clk);
      #1;
      check("reset instr", 32'(instr_cur), 32'h2);
      check("reset hiz", 32'(outputs_hiz), 32'h0);
      @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (20) @(posedge clk);
      u_jtag_ctrl_model.walk(8'h00, 1);
      // Identification readable without an instruction scan
      u_jtag_ctrl_model.scan_dr(DIN, 32, dout);
      check("id after reset", dout, ID_WORD);
      // Table of instruction codes
      foreach (rows[i]) begin
         @(posedge clk);
         #1 func_sig = 16'h5A3C ^ {12'h000, rows[i].code};
         load_ir(rows[i].code, rows[i].hiz);
         u_jtag_ctrl_model.scan_dr(DIN, 32, dout);
         #100;
         check("dr data", dout, exp_dr(rows[i].sel, func_sig));
         check("hiz after dr", 32'(outputs_hiz), 32'(rows[i].hiz));
         check("instr after dr", 32'(instr_cur), 32'(rows[i].code));
         check("oe in shift", 32'(u_jtag_ctrl_model.oe_all), 32'h1);
         check("oe idle", 32'(tdo_oe), 32'h0);
      end
      // Test reset pin drops a forced high impedance
      load_ir(4'h3, 1'h1);
      #1 u_jtag_ctrl_model.trst_n = 1'b0;
      #200 u_jtag_ctrl_model.trst_n = 1'b1;
      #100;
      check("trst instr", 32'(instr_cur), 32'h2);
      check("trst hiz", 32'(outputs_hiz), 32'h0);
      // TMS-driven Test-Logic-Reset
      u_jtag_ctrl_model.walk(8'h00, 1);
      load_ir(4'h3, 1'h1);
      u_jtag_ctrl_model.reset_tlr();
      #100;
      check("tlr instr", 32'(instr_cur), 32'h2);
      u_jtag_ctrl_model.scan_dr(DIN, 32, dout);
      check("id after tlr", dout, ID_WORD);
      // Power-up reset in mid-run
      load_ir(4'hF, 1'h0);
      @(posedge clk);
      #1 rst_n = 1'b0;
      repeat (3) @(posedge clk);
      #1 rst_n = 1'b1;
      check("rst instr", 32'(instr_cur), 32'h2);
      repeat (20) @(posedge clk);
      u_jtag_ctrl_model.walk(8'h00, 1);
      u_jtag_ctrl_model.scan_dr(DIN, 32, dout);
      check("id after rst", dout, ID_WORD);
      end_of_test();
   end
endmodule : tb_jtag_instruction_decode
